// ---- rtl/indirect_register_access_bridge.sv ----
// indirect access bridge from the local register map to analog blocks and the internal bus
`timescale 1ns/10ps
module indirect_register_access_bridge (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic [7:0]          regAddr,
    input  wire logic [7:0]          regWdata,
    input  wire logic                regWr,
    input  wire logic                regRd,
    output logic [7:0]               regRdata,
    output bridge_pkg::ana_req_s     anaReq,
    input  wire logic [7:0]          anaRdata,
    output bridge_pkg::apb_req_s     apbReq,
    input  wire logic                pready,
    input  wire logic [31:0]         prdata
);

    // ------------------------------------------------------------
    // register port decode
    // ------------------------------------------------------------
    wire wrAnaCtl  = regWr && (regAddr == bridge_pkg::OFS_ANA_CTL);
    wire wrAnaOfs  = regWr && (regAddr == bridge_pkg::OFS_ANA_OFS);
    wire wrAnaData = regWr && (regAddr == bridge_pkg::OFS_ANA_DATA);
    wire rdAnaData = regRd && (regAddr == bridge_pkg::OFS_ANA_DATA);
    wire wrBusCtl  = regWr && (regAddr == bridge_pkg::OFS_BUS_CTL);
    wire wrAdr0    = regWr && (regAddr == bridge_pkg::OFS_BUS_ADR0);
    wire wrAdr1    = regWr && (regAddr == bridge_pkg::OFS_BUS_ADR1);
    wire wrDat     = regWr && (regAddr >= bridge_pkg::OFS_BUS_DAT0)
                           && (regAddr <= bridge_pkg::OFS_BUS_DAT3);
    wire [1:0] datLane = 2'(regAddr - bridge_pkg::OFS_BUS_DAT0);

    // ------------------------------------------------------------
    // analog indirect path
    // ------------------------------------------------------------
    logic [7:0]           anaCtl_q;
    logic [7:0]           anaOfs_q;
    logic [7:0]           anaOfs_d;
    logic [7:0]           anaData_q;
    bridge_pkg::ana_req_s anaReq_q;
    bridge_pkg::ana_req_s anaReq_d;

    wire [2:0] anaSel    = anaCtl_q[bridge_pkg::ANA_SEL_LSB +: 3];
    wire       anaStep   = anaCtl_q[bridge_pkg::ANA_STEP_BIT];
    wire       anaRdArm  = anaCtl_q[bridge_pkg::ANA_READ_BIT];
    // reserved codes above the last target reach nothing
    wire       anaLive   = (anaSel != bridge_pkg::ANA_SEL_OFF)
                        && (anaSel <= bridge_pkg::ANA_SEL_LAST);
    wire       anaAccess = anaLive && (wrAnaData || rdAnaData);

    always_comb begin
        anaOfs_d = anaOfs_q;
        if (wrAnaOfs) begin
            anaOfs_d = regWdata;
        end else if (anaAccess && anaStep) begin
            anaOfs_d = anaOfs_q + 8'h01;
        end
    end

    always_comb begin
        anaReq_d       = anaReq_q;
        // a control write steers the very next access, so sel must not lag
        anaReq_d.sel   = wrAnaCtl ? regWdata[bridge_pkg::ANA_SEL_LSB +: 3] : anaSel;
        anaReq_d.addr  = anaOfs_d;
        anaReq_d.wrStb = 1'b0;
        anaReq_d.rdStb = 1'b0;
        if (wrAnaData && anaLive) begin
            // write goes out at the offset it was aimed at, before any step
            anaReq_d.addr  = anaOfs_q;
            anaReq_d.wdata = regWdata;
            anaReq_d.wrStb = 1'b1;
        end else if (wrAnaOfs && anaRdArm && anaLive) begin
            anaReq_d.rdStb = 1'b1;
        end else if (rdAnaData && anaRdArm && anaStep && anaLive) begin
            anaReq_d.rdStb = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            anaCtl_q  <= bridge_pkg::ANA_CTL_RST;
            anaOfs_q  <= bridge_pkg::ANA_OFS_RST;
            anaData_q <= bridge_pkg::ANA_DATA_RST;
            anaReq_q  <= '0;
        end else begin
            if (wrAnaCtl) begin
                anaCtl_q <= regWdata;
            end
            if (wrAnaData) begin
                anaData_q <= regWdata;
            end
            anaOfs_q <= anaOfs_d;
            anaReq_q <= anaReq_d;
        end
    end

    // ------------------------------------------------------------
    // internal bus master
    // ------------------------------------------------------------
    bridge_pkg::bus_state_e state_q;
    bridge_pkg::bus_state_e state_d;
    logic [4:0]             busCtl_q;
    logic [15:0]            busAdr_q;
    logic [31:0]            busDat_q;
    bridge_pkg::apb_req_s   apbReq_q;

    wire [1:0] busSel   = busCtl_q[bridge_pkg::BUS_SEL_LSB +: 2];
    wire       busStep  = busCtl_q[bridge_pkg::BUS_STEP_BIT];
    wire       busRdReq = busCtl_q[bridge_pkg::BUS_READ_BIT];
    wire       busEn    = busCtl_q[bridge_pkg::BUS_EN_BIT];
    wire       busIdle  = (state_q == bridge_pkg::BUS_IDLE);
    // read-only targets never see a write
    wire       busWrOk  = !busSel[1];
    wire       wrMsb    = wrDat && (datLane == 2'h3);
    wire       startRd  = busIdle && busEn && busRdReq;
    wire       startWr  = busIdle && busEn && wrMsb && busWrOk && !busRdReq;
    wire       busDone  = (state_q == bridge_pkg::BUS_ACCESS) && pready;
    wire       rdDone   = busDone && !apbReq_q.pwrite;
    wire [15:0] busStepAmt = (busSel == bridge_pkg::BUS_SEL_CTRL) ?
                             bridge_pkg::BUS_STEP_WIDE : bridge_pkg::BUS_STEP_ONE;
    // a new enable written with read-start takes effect at once
    wire       ctlEn    = regWdata[bridge_pkg::BUS_EN_BIT];
    wire       ctlRd    = regWdata[bridge_pkg::BUS_READ_BIT] && ctlEn;

    always_comb begin
        state_d = state_q;
        case (state_q)
            bridge_pkg::BUS_IDLE: begin
                if (startRd || startWr) begin
                    state_d = bridge_pkg::BUS_SETUP;
                end
            end
            bridge_pkg::BUS_SETUP: begin
                state_d = bridge_pkg::BUS_ACCESS;
            end
            bridge_pkg::BUS_ACCESS: begin
                if (pready) begin
                    state_d = bridge_pkg::BUS_IDLE;
                end
            end
            default: begin
                state_d = bridge_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= bridge_pkg::BUS_IDLE;
            busCtl_q <= 5'h00;
            busAdr_q <= bridge_pkg::BUS_ADR_RST;
            busDat_q <= bridge_pkg::BUS_DAT_RST;
            apbReq_q <= '0;
        end else begin
            state_q <= state_d;
            if (wrBusCtl && !rdDone) begin
                busCtl_q <= {regWdata[4:2], ctlRd, ctlEn};
            end else if (wrBusCtl) begin
                // completion clears read-start but keeps the other new fields
                busCtl_q <= {regWdata[4:2], 1'b0, ctlEn};
            end else if (busDone && !apbReq_q.pwrite) begin
                busCtl_q[bridge_pkg::BUS_READ_BIT] <= 1'b0;
            end else if (!busEn) begin
                busCtl_q[bridge_pkg::BUS_READ_BIT] <= 1'b0;
            end
            if (busDone && busStep) begin
                busAdr_q <= busAdr_q + busStepAmt;
            end else if (wrAdr0) begin
                busAdr_q[7:0] <= regWdata;
            end else if (wrAdr1) begin
                busAdr_q[15:8] <= regWdata;
            end
            if (busDone && !apbReq_q.pwrite) begin
                busDat_q <= prdata;
            end else if (wrDat) begin
                busDat_q[datLane*8 +: 8] <= regWdata;
            end
            if (busIdle && (startRd || startWr)) begin
                apbReq_q.target <= busSel;
                apbReq_q.psel   <= 1'b1;
                apbReq_q.pwrite <= startWr;
                apbReq_q.paddr  <= busAdr_q;
                apbReq_q.pwdata <= startWr ? {regWdata, busDat_q[23:0]} : busDat_q;
            end else if (state_q == bridge_pkg::BUS_SETUP) begin
                apbReq_q.penable <= 1'b1;
            end else if (busDone) begin
                apbReq_q.psel    <= 1'b0;
                apbReq_q.penable <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // read-back
    // ------------------------------------------------------------
    logic [7:0] regRdata_q;
    logic [7:0] rdMux;

    always_comb begin
        rdMux = 8'h00;
        if (regAddr == bridge_pkg::OFS_ANA_CTL) begin
            rdMux = anaCtl_q;
        end else if (regAddr == bridge_pkg::OFS_ANA_OFS) begin
            rdMux = anaOfs_q;
        end else if (regAddr == bridge_pkg::OFS_ANA_DATA) begin
            // live contents; unselected target reads back the last byte written
            rdMux = anaLive ? anaRdata : anaData_q;
        end else if (regAddr == bridge_pkg::OFS_BUS_CTL) begin
            rdMux = {3'h0, busCtl_q};
        end else if (regAddr == bridge_pkg::OFS_BUS_ADR0) begin
            rdMux = busAdr_q[7:0];
        end else if (regAddr == bridge_pkg::OFS_BUS_ADR1) begin
            rdMux = busAdr_q[15:8];
        end else if (wrDat || (regRd && (regAddr >= bridge_pkg::OFS_BUS_DAT0)
                                     && (regAddr <= bridge_pkg::OFS_BUS_DAT3))) begin
            rdMux = busDat_q[datLane*8 +: 8];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            regRdata_q <= 8'h00;
        end else begin
            regRdata_q <= regRd ? rdMux : 8'h00;
        end
    end

    assign regRdata = regRdata_q;
    assign anaReq   = anaReq_q;
    assign apbReq   = apbReq_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_sel_off;
        @(posedge clk) disable iff (rst)
        (anaSel == bridge_pkg::ANA_SEL_OFF) |=> !anaReq_q.wrStb && !anaReq_q.rdStb;
    endproperty
    a_sel_off: assert property (p_sel_off) else $error("strobe with target off");

    property p_ana_step;
        @(posedge clk) disable iff (rst)
        (anaLive && anaStep && rdAnaData && !wrAnaOfs) |=> anaOfs_q == $past(anaOfs_q) + 8'h01;
    endproperty
    a_ana_step: assert property (p_ana_step) else $error("analog offset did not step");

    property p_ofs_strobe;
        @(posedge clk) disable iff (rst)
        (wrAnaOfs && anaRdArm && anaLive) |=> anaReq_q.rdStb && anaReq_q.addr == anaOfs_q;
    endproperty
    a_ofs_strobe: assert property (p_ofs_strobe) else $error("no read strobe on offset");

    property p_data_strobe;
        @(posedge clk) disable iff (rst)
        (rdAnaData && anaRdArm && anaStep && anaLive) |=> anaReq_q.rdStb;
    endproperty
    a_data_strobe: assert property (p_data_strobe) else $error("no prefetch strobe");

    property p_ana_write;
        @(posedge clk) disable iff (rst)
        (wrAnaData && anaLive) |=> anaReq_q.wrStb && anaReq_q.wdata == $past(regWdata)
                                   && anaReq_q.addr == $past(anaOfs_q);
    endproperty
    a_ana_write: assert property (p_ana_write) else $error("analog write lost");

    property p_ro_target;
        @(posedge clk) disable iff (rst)
        apbReq_q.psel && apbReq_q.pwrite |-> !apbReq_q.target[1];
    endproperty
    a_ro_target: assert property (p_ro_target) else $error("write to read-only target");

    property p_rd_start;
        @(posedge clk) disable iff (rst)
        startRd |=> apbReq_q.psel && !apbReq_q.penable && !apbReq_q.pwrite
                    ##1 apbReq_q.penable;
    endproperty
    a_rd_start: assert property (p_rd_start) else $error("read did not start");

    property p_rd_done;
        @(posedge clk) disable iff (rst)
        (busDone && !apbReq_q.pwrite) |=> busDat_q == $past(prdata) && !busRdReq;
    endproperty
    a_rd_done: assert property (p_rd_done) else $error("read data or flag wrong");

    property p_bus_step;
        @(posedge clk) disable iff (rst)
        (busDone && busStep && busSel == bridge_pkg::BUS_SEL_CTRL) |=>
            busAdr_q == $past(busAdr_q) + bridge_pkg::BUS_STEP_WIDE;
    endproperty
    a_bus_step: assert property (p_bus_step) else $error("bus address step wrong");

    property p_no_enable;
        @(posedge clk) disable iff (rst)
        (busIdle && !busEn) |=> !apbReq_q.psel;
    endproperty
    a_no_enable: assert property (p_no_enable) else $error("transfer while disabled");

    property p_ofs_load;
        @(posedge clk) disable iff (rst)
        wrAnaOfs |=> anaOfs_q == $past(regWdata);
    endproperty
    a_ofs_load: assert property (p_ofs_load) else $error("offset not loaded");

    property p_write_step;
        @(posedge clk) disable iff (rst)
        (wrAnaData && anaLive && anaStep) |=> anaOfs_q == $past(anaOfs_q) + 8'h01;
    endproperty
    a_write_step: assert property (p_write_step) else $error("no step after write");

    property p_read_data;
        @(posedge clk) disable iff (rst)
        (rdAnaData && anaLive) |=> regRdata_q == $past(anaRdata);
    endproperty
    a_read_data: assert property (p_read_data) else $error("analog read data wrong");

    property p_bus_step_one;
        @(posedge clk) disable iff (rst)
        (busDone && busStep && busSel != bridge_pkg::BUS_SEL_CTRL) |=>
            busAdr_q == $past(busAdr_q) + bridge_pkg::BUS_STEP_ONE;
    endproperty
    a_bus_step_one: assert property (p_bus_step_one) else $error("narrow step wrong");

    property p_adr_low;
        @(posedge clk) disable iff (rst)
        (wrAdr0 && !(busDone && busStep)) |=> busAdr_q[7:0] == $past(regWdata);
    endproperty
    a_adr_low: assert property (p_adr_low) else $error("address low byte lost");

    property p_dat_msb;
        @(posedge clk) disable iff (rst)
        (wrMsb && !rdDone) |=> busDat_q[31:24] == $past(regWdata);
    endproperty
    a_dat_msb: assert property (p_dat_msb) else $error("data top byte lost");

    property p_hold_req;
        @(posedge clk) disable iff (rst)
        (apbReq_q.psel && !busDone) |=> apbReq_q.psel && $stable(apbReq_q.paddr)
            && $stable(apbReq_q.target) && $stable(apbReq_q.pwrite);
    endproperty
    a_hold_req: assert property (p_hold_req) else $error("request moved mid transfer");

    property p_en_clear;
        @(posedge clk) disable iff (rst)
        !busEn |-> !busRdReq;
    endproperty
    a_en_clear: assert property (p_en_clear) else $error("read-start set while disabled");

endmodule : indirect_register_access_bridge

// ---- rtl/bridge_pkg.sv ----
// constants and carrier types for the indirect register access bridge
// Summary of operation
// - three-bit analog target code routes accesses; 000 disables, 101 link or broadcast
// - analog auto-step adds one to the offset after each data read or write to a live target
// - with read-start set, writing the offset register strobes a read to the block
// - with read-start and auto-step set, each data read also strobes a read
// - an 8-bit offset picks the register inside the chosen analog block
// - writing the data window writes that byte to the block at the offset
// - reading the data window returns the block register at the offset
// - two-bit bus target: controller, id sram, config data, die id; last two read-only
// - bus auto-step adds 0x4 for the controller, 0x1 otherwise, after each transfer
// - setting bus read-start begins a read at the programmed address and target
// - the returned word lands in the four bus data bytes
// - hardware clears bus read-start once the read completes
// - the bus enable bit opens the internal bus path; target field picks slave
// - bus address is the byte at 0x49 as low half, next byte high half
// - bus data is four bytes, least significant first, msb at 0x4E
package bridge_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_ANA_CTL   = 8'h40;
    localparam logic [7:0] OFS_ANA_OFS   = 8'h41;
    localparam logic [7:0] OFS_ANA_DATA  = 8'h42;
    localparam logic [7:0] OFS_BUS_CTL   = 8'h48;
    localparam logic [7:0] OFS_BUS_ADR0  = 8'h49;
    localparam logic [7:0] OFS_BUS_ADR1  = 8'h4A;
    localparam logic [7:0] OFS_BUS_DAT0  = 8'h4B;
    localparam logic [7:0] OFS_BUS_DAT3  = 8'h4E;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int ANA_SEL_LSB   = 2;
    localparam int ANA_STEP_BIT  = 1;
    localparam int ANA_READ_BIT  = 0;
    localparam int BUS_SEL_LSB   = 3;
    localparam int BUS_STEP_BIT  = 2;
    localparam int BUS_READ_BIT  = 1;
    localparam int BUS_EN_BIT    = 0;

    // ------------------------------------------------------------
    // reset values and codes
    // ------------------------------------------------------------
    localparam logic [7:0]  ANA_CTL_RST   = 8'h00;
    localparam logic [7:0]  ANA_OFS_RST   = 8'h00;
    localparam logic [7:0]  ANA_DATA_RST  = 8'h00;
    localparam logic [15:0] BUS_ADR_RST   = 16'h0000;
    localparam logic [31:0] BUS_DAT_RST   = 32'h00000000;
    localparam logic [2:0]  ANA_SEL_OFF   = 3'h0;
    localparam logic [2:0]  ANA_SEL_LAST  = 3'h5;
    localparam logic [1:0]  BUS_SEL_CTRL  = 2'h0;
    localparam logic [15:0] BUS_STEP_WIDE = 16'h0004;
    localparam logic [15:0] BUS_STEP_ONE  = 16'h0001;

    typedef enum logic [1:0] {
        BUS_IDLE   = 2'b00,
        BUS_SETUP  = 2'b01,
        BUS_ACCESS = 2'b11
    } bus_state_e;

    typedef struct packed {
        logic [2:0] sel;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wrStb;
        logic       rdStb;
    } ana_req_s;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [15:0] paddr;
        logic [31:0] pwdata;
        logic [1:0]  target;
    } apb_req_s;

endpackage : bridge_pkg

// ---- verification/bridge_far_model.sv ----
// far-side model: analog register blocks and internal bus slaves
`timescale 1ns/10ps
module bridge_far_model (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire bridge_pkg::ana_req_s anaReq,
    output logic [7:0]                anaRdata,
    input  wire bridge_pkg::apb_req_s apbReq,
    input  wire logic [1:0]           waitCycles,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic [7:0]                wrCount,
    output logic [47:0]               wrLast
);
    logic [7:0]  anaMem [0:2047];
    logic [1:0]  waitQ;
    logic [31:0] word;
    // ------------------------------------------------------------
    // analog blocks, seeded so every target and offset differs
    // ------------------------------------------------------------
    initial begin
        for (int i = 0; i < 2048; i++) begin
            anaMem[i] = {i[10:8], 5'h00} ^ i[7:0];
        end
    end
    // no prefetch needed: contents are always visible, read strobe ignored
    assign anaRdata = anaMem[{anaReq.sel, anaReq.addr}];
    always @(posedge clk) begin
        if (anaReq.wrStb) begin
            anaMem[{anaReq.sel, anaReq.addr}] <= anaReq.wdata;
        end
    end
    // ------------------------------------------------------------
    // bus slaves with a settable number of wait states
    // ------------------------------------------------------------
    assign word   = {6'h00, apbReq.target, 8'hC3, apbReq.paddr};
    assign pready = apbReq.psel & apbReq.penable & (waitQ == waitCycles);
    // data off the bus is inverted so a stale sample never matches
    assign prdata = pready ? word : ~word;
    always @(posedge clk) begin
        waitQ <= (apbReq.penable && !pready) ? waitQ + 2'h1 : 2'h0;
        if (rst) begin
            wrCount <= 8'h00;
            wrLast  <= 48'h0;
        end else if (pready && apbReq.pwrite) begin
            wrCount <= wrCount + 8'h01;
            wrLast  <= {apbReq.paddr, apbReq.pwdata};
        end
    end
endmodule : bridge_far_model

// ---- verification/indirect_register_access_bridge_tb.sv ----
// self-checking bench for the indirect register access bridge
`timescale 1ns/10ps
module indirect_register_access_bridge_tb;
    logic                 clk;
    logic                 rst;
    logic [7:0]           regAddr;
    logic [7:0]           regWdata;
    logic                 regWr;
    logic                 regRd;
    logic [7:0]           regRdata;
    bridge_pkg::ana_req_s anaReq;
    logic [7:0]           anaRdata;
    bridge_pkg::apb_req_s apbReq;
    logic                 pready;
    logic [31:0]          prdata;
    logic [1:0]           waitCycles;
    logic [7:0]           wrCount;
    logic [47:0]          wrLast;
    bridge_pkg::ana_req_s snap;
    logic [7:0]           rd;
    int                   badCount = 0;
    int                   checked = 0;
    int                   cycles = 0;

    indirect_register_access_bridge uut (.clk(clk), .rst(rst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .anaReq(anaReq), .anaRdata(anaRdata), .apbReq(apbReq), .pready(pready),
        .prdata(prdata));
    bridge_far_model far (.clk(clk), .rst(rst), .anaReq(anaReq), .anaRdata(anaRdata),
        .apbReq(apbReq), .waitCycles(waitCycles), .pready(pready), .prdata(prdata),
        .wrCount(wrCount), .wrLast(wrLast));

    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    // ------------------------------------------------------------
    // bus tasks; one idle cycle between strobes avoids double drives
    // ------------------------------------------------------------
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checked++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            badCount++;
        end
    endtask : chk
    task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'h1;
        @(posedge clk);
        regWr <= 1'h0;
        #1 snap = anaReq;
    endtask : regWrite
    task automatic regRead(input logic [7:0] a);
        @(posedge clk);
        regAddr <= a;
        regRd   <= 1'h1;
        @(posedge clk);
        regRd <= 1'h0;
        #1 rd = regRdata;
        snap = anaReq;
    endtask : regRead
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_reset();
        for (int a = 8'h40; a <= 8'h50; a++) begin
            regRead(a[7:0]);
            chk(rd, 8'h00);
        end
        regWrite(8'h50, 8'hFF);
        regRead(8'h50);
        chk(rd, 8'h00);
    endtask : test_reset
    task automatic test_ana_write();
        for (int s = 1; s <= 5; s++) begin
            regWrite(8'h40, {3'h0, s[2:0], 2'h2});
            regWrite(8'h41, 8'h10 + s[7:0]);
            regWrite(8'h42, 8'hA0 + s[7:0]);
            chk({snap.wrStb, snap.sel, snap.addr, snap.wdata},
                {1'h1, s[2:0], 8'h10 + s[7:0], 8'hA0 + s[7:0]});
            regRead(8'h41);
            chk(rd, 8'h11 + s[7:0]);
            regRead(8'h40);
            chk(rd, {3'h0, s[2:0], 2'h2});
        end
    endtask : test_ana_write
    task automatic test_ana_read();
        regWrite(8'h40, 8'h08);
        regWrite(8'h41, 8'h20);
        chk(snap.rdStb, 1'h0);
        regRead(8'h42);
        chk(rd, 8'h60);
        regWrite(8'h40, 8'h09);
        regWrite(8'h41, 8'h30);
        chk({snap.rdStb, snap.addr}, {1'h1, 8'h30});
        regWrite(8'h40, 8'h0B);
        regRead(8'h42);
        chk({rd, snap.rdStb, snap.addr}, {8'h70, 1'h1, 8'h31});
        for (int c = 0; c < 2; c++) begin
            regWrite(8'h40, (c == 0) ? 8'h02 : 8'h1A);
            regWrite(8'h42, 8'h77);
            chk(snap.wrStb, 1'h0);
        end
        regRead(8'h41);
        chk(rd, 8'h31);
    endtask : test_ana_read
    task automatic test_apb_read();
        logic [31:0] word;
        logic [15:0] adr;
        int          n;
        for (int t = 0; t < 4; t++) begin
            waitCycles <= t[1:0];
            regWrite(8'h49, 8'h34);
            regWrite(8'h4A, 8'h12);
            regWrite(8'h48, {3'h0, t[1:0], 3'h7});
            n = 0;
            do begin
                regRead(8'h48);
                n++;
            end while (rd[1] !== 1'h0 && n < 20);
            chk(rd, {3'h0, t[1:0], 3'h5});
            for (int b = 0; b < 4; b++) begin
                regRead(8'h4B + b[7:0]);
                word[8*b+:8] = rd;
            end
            chk(word, {6'h00, t[1:0], 8'hC3, 16'h1234});
            regRead(8'h49);
            adr[7:0] = rd;
            regRead(8'h4A);
            adr[15:8] = rd;
            chk(adr, 16'h1234 + ((t == 0) ? 16'h0004 : 16'h0001));
        end
    endtask : test_apb_read
    task automatic test_apb_write();
        logic [7:0] n;
        regWrite(8'h49, 8'h00);
        regWrite(8'h4A, 8'h02);
        regWrite(8'h48, 8'h09);
        n = wrCount;
        for (int b = 0; b < 4; b++) begin
            regWrite(8'h4B + b[7:0], 8'hAA + 8'h11 * b[7:0]);
        end
        for (int i = 0; i < 20 && wrCount == n; i++) @(posedge clk);
        chk({wrCount - n, wrLast}, {8'h01, 16'h0200, 32'hDDCCBBAA});
        regWrite(8'h48, 8'h11);
        regWrite(8'h4E, 8'h55);
        repeat (12) @(posedge clk);
        chk(wrCount - n, 8'h01);
        regWrite(8'h48, 8'h02);
        repeat (6) begin
            @(posedge clk);
            #1 chk(apbReq.psel, 1'h0);
        end
        regRead(8'h48);
        chk(rd, 8'h00);
    endtask : test_apb_write
    // ------------------------------------------------------------
    // verdict and hang guard
    // ------------------------------------------------------------
    task automatic print_verdict();
        if (badCount == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            badCount++;
            print_verdict();
        end
    end
    initial begin
        rst        = 1'h1;
        regAddr    = 8'h00;
        regWdata   = 8'h00;
        regWr      = 1'h0;
        regRd      = 1'h0;
        waitCycles = 2'h0;
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        test_reset();
        test_ana_write();
        test_ana_read();
        test_apb_read();
        test_apb_write();
        print_verdict();
    end
endmodule : indirect_register_access_bridge_tb
